// [pkg/wrf_pkg.sv]
// Shared constants and carrier types for the working register file
package wrf_pkg;

  // ***********************************************************
  // Geometry and reset
  // ***********************************************************
  localparam int          WRF_NUM_REGS  = 32;
  localparam int          WRF_DATA_W    = 8;
  localparam int          WRF_SEL_W     = 5;
  localparam int          WRF_ADDR_W    = 16;
  localparam int          WRF_DISP_W    = 6;
  localparam logic [7:0]  WRF_RESET_VAL = 8'h00;

  // ***********************************************************
  // Pointer pairs and data-space map
  // ***********************************************************
  localparam logic [4:0]  WRF_PTR_A_LO  = 5'h1A; // Pointer A low byte, high at +1
  localparam logic [4:0]  WRF_PTR_B_LO  = 5'h1C; // Pointer B low byte
  localparam logic [4:0]  WRF_PTR_C_LO  = 5'h1E; // Pointer C low byte
  localparam logic [4:0]  WRF_UPPER_BIT = 5'h10; // Base of upper_register_half
  localparam logic [15:0] WRF_REG_END   = 16'h0020; // First address past the file
  localparam logic [15:0] WRF_IO_END    = 16'h0060; // First address past I/O space
  localparam logic [15:0] WRF_PTR_STEP  = 16'h0001;

  // ***********************************************************
  // Enumerations
  // ***********************************************************
  typedef enum logic [1:0] {WRF_OP_REG_REG, WRF_OP_CONST_REG, WRF_OP_SINGLE} wrf_op_kind_t;
  typedef enum logic [1:0] {WRF_PTR_A, WRF_PTR_B, WRF_PTR_C} wrf_ptr_t;
  typedef enum logic [1:0] {WRF_IND_PLAIN, WRF_IND_PREDEC, WRF_IND_POSTINC,
                            WRF_IND_DISP} wrf_ind_mode_t;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef struct packed {
    wrf_op_kind_t   kind;   // Operand form
    logic [4:0]     rd_sel; // Destination/first operand field
    logic [4:0]     rr_sel; // Second operand field
  } wrf_alu_req_t;

  typedef struct packed {
    logic           en;     // Write result this cycle
    logic           upper;  // Immediate form: field selects upper half
    logic [4:0]     sel;    // Destination field
    logic [7:0]     data;   // Result byte
  } wrf_wb_t;

  typedef struct packed {
    logic           valid;  // Data-space access this cycle
    logic           write;  // Store when set, load when clear
    logic [15:0]    addr;   // Direct address, unused when indirect
    logic [7:0]     wdata;  // Store data
  } wrf_ds_req_t;

  typedef struct packed {
    logic           valid;  // Indirect addressing this cycle
    wrf_ptr_t       ptr;    // Pointer pair used
    wrf_ind_mode_t  mode;   // Addressing mode
    logic [5:0]     disp;   // Unsigned displacement
  } wrf_ind_req_t;

endpackage

// [logic/wrf_ptr_unit.sv]
// Indirect address and pointer update arithmetic
`timescale 1ns/100ps
module wrf_ptr_unit
  import wrf_pkg::*;
(
  input  wire wrf_ind_req_t ind_req,  // Indirect request
  input  wire logic [15:0]  base,     // Current value of the chosen pair
  output logic [15:0]       addr,     // Access address
  output logic [15:0]       new_ptr,  // Value written back to the pair
  output logic              update,   // Pair is written back this cycle
  output logic              bad       // Displacement on pointer A
);

  logic [15:0] dec_val;
  logic [15:0] inc_val;

  // Full 16-bit add so carry and borrow cross the byte boundary
  assign dec_val = base - WRF_PTR_STEP;
  assign inc_val = base + WRF_PTR_STEP;

  // Address and write-back per mode
  always_comb begin
    addr    = base;
    new_ptr = base;
    update  = 1'b0;
    bad     = 1'b0;
    if (ind_req.valid) begin
      case (ind_req.mode)
        WRF_IND_PREDEC: begin
          addr    = dec_val;
          new_ptr = dec_val;
          update  = 1'b1;
        end
        WRF_IND_POSTINC: begin
          addr    = base;
          new_ptr = inc_val;
          update  = 1'b1;
        end
        WRF_IND_DISP: begin
          // Pointer A has no displacement form; flag it and use the bare base
          if (ind_req.ptr == WRF_PTR_A) begin
            bad = 1'b1;
          end else begin
            addr = base + {10'h000, ind_req.disp};
          end
        end
        default: begin
          addr = base;
        end
      endcase
    end
  end

endmodule

// [logic/wrf_regfile.sv]
// Working register file with pointer pairs and data-space decode
// Contract
// - Thirty-two eight-bit registers, each readable within one cycle.
// - Two operands out and one result written in the same cycle.
// - Six registers also form three 16-bit pointers A, B, C.
// - A is 27:26, B is 29:28, C is 31:30, high:low.
// - Pointer C supplies the full constant-table byte address.
// - Data addresses 0x00-0x1F read and write register n.
// - Data addresses 0x20-0x5F decode to I/O space, not registers.
// - Indirect accesses below 0x20 reach the addressed working register.
// - Immediate forms select only registers 16 through 31.
// - All other register operations may select any of the 32 registers.
// - Operands for register-register, constant-register and single-register forms.
// - Pointer C upper fifteen bits pick the word, bit zero the byte.
// - Pre-decrement uses and stores the decremented pointer.
// - Post-increment uses the old pointer, then stores it plus one.
// - Displacement only on B or C, six-bit unsigned offset added.
`timescale 1ns/100ps
module wrf_regfile
  import wrf_pkg::*;
(
  input  wire logic         clock,          // System clock, 200 MHz
  input  wire logic         reset,          // Synchronous, active high
  input  wire wrf_alu_req_t alu_req,        // Operand selection from decoder
  output logic [7:0]        op_d,           // First operand to ALU
  output logic [7:0]        op_r,           // Second operand to ALU
  input  wire wrf_wb_t      wb,             // ALU result write-back
  input  wire wrf_ds_req_t  ds_req,         // Load/store data-space access
  input  wire wrf_ind_req_t ind_req,        // Indirect addressing request
  output logic [15:0]       ds_addr_eff,    // Effective data address
  output logic              ds_hit_reg,     // Access lands in the register file
  output logic              ds_hit_io,      // Access lands in I/O space
  output logic [7:0]        ds_rdata,       // Load data from register file
  output logic              ind_bad,        // Displacement asked on pointer A
  output logic [14:0]       lpm_word_addr,  // Constant-table word address
  output logic              lpm_high_byte   // Constant-table byte pick
);

  // ***********************************************************
  // Storage
  // ***********************************************************
  logic [7:0]  regs      [WRF_NUM_REGS];
  logic [7:0]  next_regs [WRF_NUM_REGS];
  logic [15:0] ptr_val   [3];
  logic [15:0] ind_base;
  logic [15:0] ind_addr;
  logic [15:0] ind_new;
  logic        ind_upd;
  logic [4:0]  ptr_lo;
  logic [4:0]  ptr_hi;
  logic [4:0]  wb_idx;
  logic [4:0]  rd_idx;
  logic        ds_store_reg;

  // Pair views, one per pointer
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_ptr
      assign ptr_val[gp] = {regs[WRF_PTR_A_LO + 5'(2 * gp + 1)],
                            regs[WRF_PTR_A_LO + 5'(2 * gp)]};
    end
  endgenerate

  // ***********************************************************
  // Operand read
  // ***********************************************************
  // Immediate forms carry a 4-bit field; the top bit is implied
  assign rd_idx = (alu_req.kind == WRF_OP_CONST_REG) ?
                  (WRF_UPPER_BIT | {1'b0, alu_req.rd_sel[3:0]}) : alu_req.rd_sel;

  // Reads come straight off storage, so a write this cycle is not seen yet
  always_comb begin
    op_d = regs[rd_idx];
    case (alu_req.kind)
      WRF_OP_REG_REG:   op_r = regs[alu_req.rr_sel];
      WRF_OP_CONST_REG: op_r = 8'h00;
      WRF_OP_SINGLE:    op_r = 8'h00;
      default:          op_r = 8'h00;
    endcase
  end

  // ***********************************************************
  // Indirect addressing
  // ***********************************************************
  assign ind_base = ptr_val[ind_req.ptr];
  assign ptr_lo   = WRF_PTR_A_LO + {2'b00, ind_req.ptr, 1'b0};
  assign ptr_hi   = ptr_lo + 5'h01;

  wrf_ptr_unit u_ptr (
    .ind_req (ind_req),
    .base    (ind_base),
    .addr    (ind_addr),
    .new_ptr (ind_new),
    .update  (ind_upd),
    .bad     (ind_bad)
  );

  // ***********************************************************
  // Data-space decode
  // ***********************************************************
  // Indirect address replaces the direct one, so pointers can index the file
  assign ds_addr_eff = ind_req.valid ? ind_addr : ds_req.addr;
  assign ds_hit_reg  = ds_req.valid && (ds_addr_eff < WRF_REG_END);
  assign ds_hit_io   = ds_req.valid && (ds_addr_eff >= WRF_REG_END) &&
                       (ds_addr_eff < WRF_IO_END);
  assign ds_store_reg = ds_hit_reg && ds_req.write;

  // Load data is the stored value; zero when the access goes elsewhere
  assign ds_rdata = (ds_hit_reg && !ds_req.write) ? regs[ds_addr_eff[4:0]] : 8'h00;

  // ***********************************************************
  // Constant-table address
  // ***********************************************************
  assign lpm_word_addr = ptr_val[WRF_PTR_C][15:1];
  assign lpm_high_byte = ptr_val[WRF_PTR_C][0];

  // ***********************************************************
  // Write path
  // ***********************************************************
  assign wb_idx = wb.upper ? (WRF_UPPER_BIT | {1'b0, wb.sel[3:0]}) : wb.sel;

  // Priority low to high: ALU result, store, pointer step. The pointer step
  // wins because losing it would corrupt the address stream of a loop.
  always_comb begin
    next_regs = regs;
    if (wb.en) begin
      next_regs[wb_idx] = wb.data;
    end
    if (ds_store_reg) begin
      next_regs[ds_addr_eff[4:0]] = ds_req.wdata;
    end
    if (ind_upd) begin
      next_regs[ptr_lo] = ind_new[7:0];
      next_regs[ptr_hi] = ind_new[15:8];
    end
  end

  // Registers only; cleared on reset
  always_ff @(posedge clock) begin
    if (reset) begin
      regs <= '{default: WRF_RESET_VAL};
    end else begin
      regs <= next_regs;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  // Reset masks the checks below except reset_clear_a, since stored state is being forced
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Request shapes only; address and write-back are checked in the properties
  sequence postinc_req_s;
    ind_req.valid && ind_req.mode == WRF_IND_POSTINC;
  endsequence

  sequence predec_req_s;
    ind_req.valid && ind_req.mode == WRF_IND_PREDEC;
  endsequence

  wb_store_a: assert property (
    wb.en && !ds_store_reg && !ind_upd |=> regs[$past(wb_idx)] == $past(wb.data))
    else $error("ALU result not stored");

  postinc_ptr_a: assert property (
    postinc_req_s |-> ind_addr == ind_base
    ##1 ptr_val[$past(ind_req.ptr)] == $past(ind_base) + WRF_PTR_STEP)
    else $error("Post-increment pointer wrong");

  predec_ptr_a: assert property (
    predec_req_s |-> ind_addr == ind_base - WRF_PTR_STEP
    ##1 ptr_val[$past(ind_req.ptr)] == $past(ind_addr))
    else $error("Pre-decrement pointer wrong");

  // Displacement never writes the pair back
  disp_addr_a: assert property (
    ind_req.valid && ind_req.mode == WRF_IND_DISP && ind_req.ptr != WRF_PTR_A
    |-> ind_addr == ind_base + {10'h000, ind_req.disp} && !ind_bad && !ind_upd)
    else $error("Displacement address wrong");

  upper_half_a: assert property (
    alu_req.kind == WRF_OP_CONST_REG |-> op_d == regs[{1'b1, alu_req.rd_sel[3:0]}])
    else $error("Immediate form left upper half");

  io_route_a: assert property (
    ds_req.valid && ds_addr_eff >= WRF_REG_END && ds_addr_eff < WRF_IO_END
    |-> ds_hit_io && !ds_hit_reg)
    else $error("I/O address hit register file");

  reg_load_a: assert property (
    ds_req.valid && !ds_req.write && ds_addr_eff < WRF_REG_END
    |-> ds_rdata == regs[ds_addr_eff[4:0]] && !ds_hit_io)
    else $error("Register load data wrong");

  // A bypass would show the new byte before the stored one matches it
  old_value_a: assert property (
    wb.en && wb_idx == rd_idx |-> op_d != wb.data || regs[rd_idx] == wb.data)
    else $error("Same-cycle read saw new value");

  lpm_addr_a: assert property (
    ind_upd && ind_req.ptr == WRF_PTR_C |=>
    {lpm_word_addr, lpm_high_byte} == $past(ind_new))
    else $error("Constant-table address not from pointer C");

  // Both bytes of a stepped pair land on one edge, even over a store
  pair_step_a: assert property (
    ind_upd |=> {regs[$past(ptr_hi)], regs[$past(ptr_lo)]} == $past(ind_new))
    else $error("Pointer pair step split");

  // Pointer into the low 32 addresses lands on the register file
  ind_reg_a: assert property (
    ind_req.valid && ds_req.valid && ind_addr < WRF_REG_END
    |-> ds_hit_reg && !ds_hit_io && ds_addr_eff == ind_addr)
    else $error("Indexed access missed the register file");

  // Reset leaves both selected operands zero; this one is not masked by reset
  reset_clear_a: assert property (
    disable iff (1'b0) reset |=> op_d == WRF_RESET_VAL && op_r == 8'h00)
    else $error("Register not cleared by reset");

endmodule

// [bench/wrf_cpu_model.sv]
// Behavioural CPU datapath that issues register file requests
`timescale 1ns/100ps
module wrf_cpu_model
  import wrf_pkg::*;
(
  output wrf_alu_req_t alu_req, // Operand selection
  output wrf_wb_t      wb,      // Result write-back
  output wrf_ds_req_t  ds_req,  // Data-space access
  output wrf_ind_req_t ind_req  // Indirect request
);
  // ***********************************************************
  // Request tasks, called just after a falling edge only
  // ***********************************************************
  task automatic alu(wrf_op_kind_t k, logic [4:0] d, logic [4:0] r);
    alu_req = '{k, d, r};
  endtask
  task automatic wbk(logic e, logic u, logic [4:0] s, logic [7:0] v);
    wb = '{e, u, s, v};
  endtask
  task automatic ds(logic v, logic w, logic [15:0] a, logic [7:0] d);
    ds_req = '{v, w, a, d};
  endtask
  task automatic ind(wrf_ptr_t p, wrf_ind_mode_t m, logic [5:0] d);
    ind_req = '{1'b1, p, m, d};
  endtask
  // Everything quiet, so no stale request leaks into the next cycle
  task automatic idle();
    alu_req = '0;
    wb      = '0;
    ds_req  = '0;
    ind_req = '0;
  endtask
  initial idle();
endmodule

// [bench/cpu_working_register_file_tb.sv]
// Self-checking bench for the working register file
`timescale 1ns/100ps
module cpu_working_register_file_tb;
  import wrf_pkg::*;
  typedef struct packed {
    logic         up;
    logic [4:0]   sel;
    logic [7:0]   data;
    wrf_op_kind_t kind;
    logic [4:0]   rd;
    logic [7:0]   exp;
  } wrf_row_t;
  logic         clock;
  logic         reset;
  wrf_alu_req_t alu_req;
  wrf_wb_t      wb;
  wrf_ds_req_t  ds_req;
  wrf_ind_req_t ind_req;
  logic [7:0]   op_d;
  logic [7:0]   op_r;
  logic [15:0]  ds_addr_eff;
  logic         ds_hit_reg;
  logic         ds_hit_io;
  logic [7:0]   ds_rdata;
  logic         ind_bad;
  logic [14:0]  lpm_word_addr;
  logic         lpm_high_byte;
  int           errors;
  int           cmp_count;
  // Last row reads r31 through the upper-half field of a lower write
  wrf_row_t rows [4] = '{'{1'b0, 5'h00, 8'h11, WRF_OP_REG_REG, 5'h00, 8'h11},
                        '{1'b1, 5'h03, 8'hA5, WRF_OP_CONST_REG, 5'h03, 8'hA5},
                        '{1'b1, 5'h1F, 8'h3C, WRF_OP_SINGLE, 5'h1F, 8'h3C},
                        '{1'b0, 5'h0F, 8'hF0, WRF_OP_CONST_REG, 5'h0F, 8'h3C}};
  // ***********************************************************
  // Clock, design and datapath model
  // ***********************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  wrf_regfile i_wrf_regfile (.clock(clock), .reset(reset), .alu_req(alu_req),
    .op_d(op_d), .op_r(op_r), .wb(wb), .ds_req(ds_req), .ind_req(ind_req),
    .ds_addr_eff(ds_addr_eff), .ds_hit_reg(ds_hit_reg), .ds_hit_io(ds_hit_io),
    .ds_rdata(ds_rdata), .ind_bad(ind_bad), .lpm_word_addr(lpm_word_addr),
    .lpm_high_byte(lpm_high_byte));
  wrf_cpu_model i_wrf_cpu_model (.alu_req(alu_req), .wb(wb), .ds_req(ds_req),
    .ind_req(ind_req));
  // ***********************************************************
  // Helpers
  // ***********************************************************
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (exp !== got) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One-cycle store through the data space, then quiet
  task automatic st(logic [15:0] a, logic [7:0] d);
    @(negedge clock);
    i_wrf_cpu_model.ds(1'b1, 1'b1, a, d);
    @(negedge clock);
    i_wrf_cpu_model.idle();
  endtask
  // Watchdog at 2000 cycles counts an error, so a stuck sequence still reaches the report
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    summarize();
  end
  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    // All registers clear and reachable at data addresses 0x00-0x1F
    for (int n = 0; n < 32; n++) begin
      @(negedge clock);
      i_wrf_cpu_model.ds(1'b1, 1'b0, 16'(n), 8'h00);
      #1;
      chk("reset value", 16'h0000, ds_rdata);
      chk("hit_reg", 16'h0001, ds_hit_reg);
    end
    // Table: write back, then read through each operand form
    foreach (rows[i]) begin
      @(negedge clock);
      i_wrf_cpu_model.idle();
      i_wrf_cpu_model.wbk(1'b1, rows[i].up, rows[i].sel, rows[i].data);
      @(negedge clock);
      i_wrf_cpu_model.wbk(1'b0, 1'b0, 5'h00, 8'h00);
      i_wrf_cpu_model.alu(rows[i].kind, rows[i].rd, rows[i].rd);
      #1;
      chk("op_d", rows[i].exp, op_d);
      chk("op_r", (rows[i].kind == WRF_OP_REG_REG) ? rows[i].exp : 8'h00, op_r);
    end
    // Write and read of one register in the same cycle
    @(negedge clock);
    i_wrf_cpu_model.wbk(1'b1, 1'b0, 5'h02, 8'h77);
    i_wrf_cpu_model.alu(WRF_OP_REG_REG, 5'h02, 5'h02);
    #1;
    chk("op_d old", 16'h0000, op_d);
    @(negedge clock);
    i_wrf_cpu_model.wbk(1'b0, 1'b0, 5'h00, 8'h00);
    #1;
    chk("op_d new", 16'h0077, op_d);
    // Decode edges of register and I/O space; I/O store leaves r5 alone
    st(16'h0025, 8'hEE);
    for (int k = 0; k < 4; k++) begin
      logic [15:0] a;
      a = (k == 0) ? 16'h001F : (k == 1) ? 16'h0020 : (k == 2) ? 16'h005F : 16'h0060;
      @(negedge clock);
      i_wrf_cpu_model.ds(1'b1, 1'b0, a, 8'h00);
      #1;
      chk("hit_reg", 16'(a < 16'h0020), ds_hit_reg);
      chk("hit_io", 16'(a >= 16'h0020 && a < 16'h0060), ds_hit_io);
    end
    @(negedge clock);
    i_wrf_cpu_model.ds(1'b1, 1'b0, 16'h0005, 8'h00);
    #1;
    chk("r5 after io store", 16'h0000, ds_rdata);
    // Pointer C at 0x00FF: table address, then step across the byte boundary
    st(16'h001E, 8'hFF);
    st(16'h001F, 8'h00);
    chk("lpm word", 16'h007F, lpm_word_addr);
    chk("lpm byte", 16'h0001, lpm_high_byte);
    @(negedge clock);
    i_wrf_cpu_model.ind(WRF_PTR_C, WRF_IND_POSTINC, 6'h00);
    i_wrf_cpu_model.ds(1'b1, 1'b0, 16'h0000, 8'h00);
    #1;
    chk("postinc addr", 16'h00FF, ds_addr_eff);
    @(negedge clock);
    i_wrf_cpu_model.ind(WRF_PTR_C, WRF_IND_PREDEC, 6'h00);
    #1;
    chk("carry word", 16'h0080, lpm_word_addr);
    chk("predec addr", 16'h00FF, ds_addr_eff);
    @(negedge clock);
    i_wrf_cpu_model.idle();
    chk("borrow word", 16'h007F, lpm_word_addr);
    // Displacement on B reaches I/O; on A it is flagged
    st(16'h001C, 8'h10);
    st(16'h0005, 8'h5A);
    st(16'h001A, 8'h05);
    @(negedge clock);
    i_wrf_cpu_model.ind(WRF_PTR_B, WRF_IND_DISP, 6'h3F);
    i_wrf_cpu_model.ds(1'b1, 1'b0, 16'h0000, 8'h00);
    #1;
    chk("disp addr", 16'h004F, ds_addr_eff);
    chk("disp io", 16'h0001, ds_hit_io);
    @(negedge clock);
    i_wrf_cpu_model.ind(WRF_PTR_A, WRF_IND_DISP, 6'h01);
    #1;
    chk("bad disp", 16'h0001, ind_bad);
    @(negedge clock);
    i_wrf_cpu_model.ind(WRF_PTR_A, WRF_IND_PLAIN, 6'h00);
    #1;
    chk("ptr A addr", 16'h0005, ds_addr_eff);
    chk("indexed load", 16'h005A, ds_rdata);
    // Mid-run reset clears a written register
    @(negedge clock);
    i_wrf_cpu_model.idle();
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    i_wrf_cpu_model.ds(1'b1, 1'b0, 16'h0005, 8'h00);
    #1;
    chk("r5 after reset", 16'h0000, ds_rdata);
    summarize();
  end
endmodule
